// file: logic/gsli_top.sv
// Pad logic with network status indicator and single converter read path.
`timescale 1ns/1ns
`include "gsli_map.svh"
module gsli_top
(
   // Clock and reset.
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   // Pad configuration and access.
   input  wire logic [`GSLI_NPADS-1:0]    pad_out_en_cfg,
   input  wire logic [`GSLI_NPADS-1:0]    pad_wr_val,
   input  wire logic                      pad_rd_req,
   output logic [`GSLI_NPADS-1:0]         pad_rd_val_q,
   output logic                           pad_rd_ack_q,
   // Pads.
   input  wire logic [`GSLI_NPADS-1:0]    pad_i,
   output logic [`GSLI_NPADS-1:0]         pad_o,
   output logic [`GSLI_NPADS-1:0]         pad_oe,
   // Indicator enable command and network state.
   input  wire gsli_pkg::gsli_cfg_s       cfg_cmd,
   input  wire gsli_pkg::gsli_net_e       net_state,
   input  wire logic                      paging_wake,
   output logic                           stat_alt_en_q,
   // Converter.
   input  wire gsli_pkg::gsli_adcreq_s    adc_cmd,
   input  wire logic [`GSLI_ADC_W-1:0]    analog_input_one,
   output logic [`GSLI_ADC_W-1:0]         adc_code_q,
   output logic [`GSLI_MV_W-1:0]          adc_mv_q,
   output logic                           adc_done_q,
   output logic                           adc_busy_q
);
   import gsli_pkg::*;

   localparam int ON_CYC  = `GSLI_ON_SEC * `GSLI_SEC_CYC;
   localparam int PER_CYC = (`GSLI_ON_SEC + `GSLI_OFF_SEC) * `GSLI_SEC_CYC;

   // ------------------------------------------------------------------------
   // Indicator enable
   // ------------------------------------------------------------------------
   // alternate function enable
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         stat_alt_en_q <= 1'b0;
      else if (cfg_cmd.valid && cfg_cmd.pin == `GSLI_CFG_PIN && cfg_cmd.dir == `GSLI_CFG_DIR)
         stat_alt_en_q <= (cfg_cmd.val == `GSLI_CFG_ALT);
   end

   // ------------------------------------------------------------------------
   // Blink timebase
   // ------------------------------------------------------------------------
   logic [`GSLI_TICK_W-1:0] tick_q;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         tick_q <= '0;
      else if (tick_q == `GSLI_TICK_W'(PER_CYC - 1))
         tick_q <= '0;
      else
         tick_q <= tick_q + `GSLI_TICK_W'(1);
   end

   logic blink_on;
   assign blink_on = (tick_q < `GSLI_TICK_W'(ON_CYC));

   // In power saving, a paging wakeup lights the indicator for one on-phase.
   logic [`GSLI_TICK_W-1:0] wake_cnt_q;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         wake_cnt_q <= '0;
      else if (paging_wake)
         wake_cnt_q <= `GSLI_TICK_W'(ON_CYC);
      else if (wake_cnt_q != '0)
         wake_cnt_q <= wake_cnt_q - `GSLI_TICK_W'(1);
   end

   logic stat_lvl;
   always_comb
   begin
      case (net_state)
         GSLI_OFF:   stat_lvl = 1'b0;
         GSLI_UNREG: stat_lvl = 1'b1;
         GSLI_IDLE:  stat_lvl = blink_on;
         GSLI_CONN:  stat_lvl = blink_on;
         GSLI_PSAVE: stat_lvl = (wake_cnt_q != '0);
         default:    stat_lvl = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------------
   // Pads
   // ------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `GSLI_NPADS; g++)
      begin : g_pad
         always_ff @(posedge clk)
         begin
            if (!rst_b)
            begin
               pad_o[g]  <= 1'b0;
               pad_oe[g] <= 1'b0;
            end
            else if (g == `GSLI_PAD_STAT && stat_alt_en_q)
            begin
               pad_o[g]  <= stat_lvl;
               pad_oe[g] <= 1'b1;
            end
            else
            begin
               pad_o[g]  <= pad_wr_val[g];
               pad_oe[g] <= pad_out_en_cfg[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pad_rd_val_q <= '0;
         pad_rd_ack_q <= 1'b0;
      end
      else
      begin
         pad_rd_ack_q <= pad_rd_req;
         if (pad_rd_req)
            pad_rd_val_q <= (pad_i & ~pad_oe) | (pad_o & pad_oe);
      end
   end

   // ------------------------------------------------------------------------
   // Converter
   // ------------------------------------------------------------------------
   logic [`GSLI_ADC_W-1:0] hold_q;
   logic                   scale_q;
   logic [`GSLI_PROD_W-1:0] prod;
   assign prod = `GSLI_PROD_W'(hold_q) * `GSLI_PROD_W'(`GSLI_FULL_MV);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         hold_q     <= '0;
         scale_q    <= 1'b0;
         adc_busy_q <= 1'b0;
      end
      else
      begin
         scale_q    <= 1'b0;
         adc_busy_q <= 1'b0;
         if (adc_cmd.valid && adc_cmd.chan == `GSLI_ADC_CH && adc_cmd.fmt == `GSLI_ADC_FMT && !adc_busy_q)
         begin
            hold_q     <= analog_input_one;
            scale_q    <= 1'b1;
            adc_busy_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         adc_code_q <= '0;
         adc_mv_q   <= '0;
         adc_done_q <= 1'b0;
      end
      else
      begin
         adc_done_q <= scale_q;
         if (scale_q)
         begin
            adc_code_q <= hold_q;
            adc_mv_q   <= prod[`GSLI_ADC_W+`GSLI_MV_W-1:`GSLI_ADC_W];
         end
      end
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   sequence s_conv_req;
      adc_cmd.valid && adc_cmd.chan == `GSLI_ADC_CH && adc_cmd.fmt == `GSLI_ADC_FMT && !adc_busy_q;
   endsequence
   sequence s_conv_done;
      ##2 adc_done_q;
   endsequence

   property p_off_low;
      @(posedge clk) disable iff (!rst_b)
      stat_alt_en_q && net_state == GSLI_OFF |=> !pad_o[`GSLI_PAD_STAT] || $past(net_state) != GSLI_OFF;
   endproperty
   a_off_low: assert property (p_off_low) else $error("indicator not low when off");

   property p_unreg_high;
      @(posedge clk) disable iff (!rst_b)
      stat_alt_en_q && $stable(stat_alt_en_q) && net_state == GSLI_UNREG ##1 stat_alt_en_q |-> pad_o[`GSLI_PAD_STAT];
   endproperty
   a_unreg_high: assert property (p_unreg_high) else $error("indicator not high when unregistered");

   property p_blink_phase;
      @(posedge clk) disable iff (!rst_b)
      tick_q == `GSLI_TICK_W'(ON_CYC) |-> !blink_on && $past(blink_on);
   endproperty
   a_blink_phase: assert property (p_blink_phase) else $error("blink on phase length wrong");

   property p_tick_wrap;
      @(posedge clk) disable iff (!rst_b)
      tick_q == `GSLI_TICK_W'(PER_CYC - 1) |=> tick_q == '0;
   endproperty
   a_tick_wrap: assert property (p_tick_wrap) else $error("blink period wrong");

   property p_conn_blink;
      @(posedge clk) disable iff (!rst_b)
      stat_alt_en_q && net_state == GSLI_CONN |=> pad_o[`GSLI_PAD_STAT] == $past(blink_on) || !$past(stat_alt_en_q);
   endproperty
   a_conn_blink: assert property (p_conn_blink) else $error("connecting blink wrong");

   property p_wake;
      @(posedge clk) disable iff (!rst_b)
      paging_wake |=> wake_cnt_q == `GSLI_TICK_W'(ON_CYC);
   endproperty
   a_wake: assert property (p_wake) else $error("wake pulse not started");

   property p_conv;
      @(posedge clk) disable iff (!rst_b)
      s_conv_req |-> s_conv_done;
   endproperty
   a_conv: assert property (p_conv) else $error("conversion not completed in two cycles");

   property p_mv;
      @(posedge clk) disable iff (!rst_b)
      s_conv_req ##2 1'b1 |-> adc_mv_q == `GSLI_MV_W'((`GSLI_PROD_W'($past(analog_input_one, 2))
         * `GSLI_PROD_W'(`GSLI_FULL_MV)) >> `GSLI_ADC_W);
   endproperty
   a_mv: assert property (p_mv) else $error("millivolt scaling wrong");

   property p_rd;
      @(posedge clk) disable iff (!rst_b)
      pad_rd_req && pad_oe == '0 |=> pad_rd_ack_q && pad_rd_val_q == $past(pad_i);
   endproperty
   a_rd: assert property (p_rd) else $error("input read wrong");

   property p_drive;
      @(posedge clk) disable iff (!rst_b)
      !stat_alt_en_q ##1 !stat_alt_en_q |-> pad_oe == $past(pad_out_en_cfg);
   endproperty
   a_drive: assert property (p_drive) else $error("output enable not per config");
endmodule

// file: logic/gsli_map.svh
// Constants for the status LED pad block: counts, codes and field positions.
// ----------------------------------------------------------------------------
// Summary of operation
// - Input pad reports externally driven level
// - Output pad drives push-pull both ways
// - Indicator low when off, high unregistered
// - Registered idle: one second on, two off
// - Connecting: same one on, two off blink
// - Power saving: indicator follows paging wakeups
// - Converter samples, holds, yields ten-bit word
// - Read command 1,2 returns millivolts
// - Input read returns level at read time
// ----------------------------------------------------------------------------
`ifndef GSLI_MAP_SVH
`define GSLI_MAP_SVH
`define GSLI_NPADS        10
`define GSLI_CLK_HZ       20000000
`define GSLI_SEC_CYC      (`GSLI_CLK_HZ / 1)
`define GSLI_TICK_W       26
`define GSLI_ON_SEC       1
`define GSLI_OFF_SEC      2
`define GSLI_ADC_W        10
`define GSLI_MV_W         11
`define GSLI_FULL_MV      1800
`define GSLI_PROD_W       22
`define GSLI_CFG_PIN      4'h1
`define GSLI_CFG_DIR      2'h0
`define GSLI_CFG_ALT      2'h2
`define GSLI_ADC_CH       2'h1
`define GSLI_ADC_FMT      2'h2
`define GSLI_PAD_STAT     0
`endif

// file: logic/gsli_pkg.sv
// Types shared by the status LED pad block.
package gsli_pkg;
   typedef enum logic [2:0] {GSLI_OFF, GSLI_UNREG, GSLI_IDLE, GSLI_PSAVE, GSLI_CONN} gsli_net_e;
   typedef enum logic [1:0] {GSLI_PAD_IN, GSLI_PAD_OUT, GSLI_PAD_ALT} gsli_mode_e;
   typedef struct packed {
      logic       valid;
      logic [3:0] pin;
      logic [1:0] dir;
      logic [1:0] val;
   } gsli_cfg_s;
   typedef struct packed {
      logic       valid;
      logic [1:0] chan;
      logic [1:0] fmt;
   } gsli_adcreq_s;
endpackage

// file: verification/gsli_ext.sv
// Model of the devices wired to the pads.
`timescale 1ns/1ns
`include "gsli_map.svh"
module gsli_ext
(
   // Pads.
   pad_o,
   pad_oe,
   // Level the external devices apply.
   drive_val,
   pad_i
);
   input  wire logic [`GSLI_NPADS-1:0] pad_o;
   input  wire logic [`GSLI_NPADS-1:0] pad_oe;
   input  wire logic [`GSLI_NPADS-1:0] drive_val;
   output logic      [`GSLI_NPADS-1:0] pad_i;
   // external level, pad drive
   // A pad that the block drives shows the block's level; otherwise the device's.
   assign pad_i = (pad_oe & pad_o) | (~pad_oe & drive_val);
endmodule

// file: verification/testbench.sv
// Self-checking bench for the status LED pad block.
`timescale 1ns/1ns
`include "gsli_map.svh"
module testbench;
   import gsli_pkg::*;
   logic                    clk, rst_b, pad_rd_req, paging_wake, pad_rd_ack_q, stat_alt_en_q, adc_done_q, adc_busy_q;
   logic [`GSLI_NPADS-1:0]  out_en, wr_val, pad_i, pad_o, pad_oe, rd_val, drive_val;
   logic [`GSLI_ADC_W-1:0]  analog_in, adc_code_q;
   logic [`GSLI_MV_W-1:0]   adc_mv_q;
   gsli_cfg_s               cfg_cmd;
   gsli_adcreq_s            adc_cmd;
   gsli_net_e               net_state;
   int                      fail_count, total_checks;
   gsli_top gsli_top_i (.clk(clk), .rst_b(rst_b), .pad_out_en_cfg(out_en), .pad_wr_val(wr_val),
      .pad_rd_req(pad_rd_req), .pad_rd_val_q(rd_val), .pad_rd_ack_q(pad_rd_ack_q), .pad_i(pad_i),
      .pad_o(pad_o), .pad_oe(pad_oe), .cfg_cmd(cfg_cmd), .net_state(net_state),
      .paging_wake(paging_wake), .stat_alt_en_q(stat_alt_en_q), .adc_cmd(adc_cmd),
      .analog_input_one(analog_in), .adc_code_q(adc_code_q), .adc_mv_q(adc_mv_q),
      .adc_done_q(adc_done_q), .adc_busy_q(adc_busy_q));
   gsli_ext gsli_ext_i (.pad_o(pad_o), .pad_oe(pad_oe), .drive_val(drive_val), .pad_i(pad_i));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task t_read(input logic [`GSLI_NPADS-1:0] exp);
      pad_rd_req = 1'b1;
      @(negedge clk);
      pad_rd_req = 1'b0;
      chk(pad_rd_ack_q, 1'b1);
      chk(rd_val, exp);
      @(negedge clk);
      chk(pad_rd_ack_q, 1'b0);
   endtask
   task t_pads;
      drive_val = 10'h2b5;
      @(negedge clk);
      t_read(10'h2b5);
      out_en = 10'h3ff;
      wr_val = 10'h14a;
      repeat (2) @(negedge clk);
      chk(pad_oe, 10'h3ff);
      chk(pad_o, 10'h14a);
      t_read(10'h14a);
      out_en = 10'h0;
   endtask
   task t_net(input gsli_net_e st, input logic exp);
      net_state = st;
      repeat (2) @(negedge clk);
      chk(pad_o[0], exp);
   endtask
   task t_stat;
      cfg_cmd = '{1'b1, 4'h1, 2'h0, 2'h2};
      @(negedge clk);
      cfg_cmd = '{1'b1, 4'h1, 2'h0, 2'h1};
      chk(stat_alt_en_q, 1'b1);
      @(negedge clk);
      cfg_cmd = '{1'b1, 4'h2, 2'h0, 2'h2};
      chk(stat_alt_en_q, 1'b0);
      chk(pad_oe[0], 1'b1);
      @(negedge clk);
      cfg_cmd = '{1'b1, 4'h1, 2'h0, 2'h2};
      chk(stat_alt_en_q, 1'b0);
      chk(pad_oe[0], 1'b0);
      @(negedge clk);
      cfg_cmd = '0;
      chk(stat_alt_en_q, 1'b1);
      @(negedge clk);
      chk(pad_oe[0], 1'b1);
      t_net(GSLI_UNREG, 1'b1);
      t_net(GSLI_OFF, 1'b0);
      t_net(GSLI_IDLE, 1'b1);
      t_net(GSLI_CONN, 1'b1);
      t_net(GSLI_PSAVE, 1'b0);
      paging_wake = 1'b1;
      @(negedge clk);
      paging_wake = 1'b0;
      @(negedge clk);
      chk(pad_o[0], 1'b1);
      t_net(GSLI_OFF, 1'b0);
   endtask
   task t_adc(input logic [9:0] code, input logic [1:0] fmt);
      analog_in = code;
      adc_cmd = '{1'b1, 2'h1, fmt};
      @(negedge clk);
      adc_cmd = '0;
      analog_in = ~code;
      chk(adc_busy_q, fmt == 2'h2);
      @(negedge clk);
      chk(adc_done_q, fmt == 2'h2);
      if (fmt == 2'h2)
      begin
         chk(adc_code_q, code);
         chk(adc_mv_q, 16'((32'(code) * 32'd1800) >> 10));
      end
   endtask
   task t_adc_busy;
      analog_in = 10'h0aa;
      adc_cmd = '{1'b1, 2'h1, 2'h2};
      repeat (2) @(negedge clk);
      adc_cmd = '0;
      chk(adc_busy_q, 1'b0);
      chk(adc_done_q, 1'b1);
      chk(adc_code_q, 10'h0aa);
      @(negedge clk);
      chk(adc_done_q, 1'b0);
   endtask
   initial
   begin
      fail_count = 0;
      total_checks = 0;
      rst_b = 1'b0;
      {pad_rd_req, paging_wake} = 2'b00;
      {out_en, wr_val, drive_val, analog_in} = '0;
      cfg_cmd = '0;
      adc_cmd = '0;
      net_state = GSLI_OFF;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      t_pads();
      t_stat();
      t_adc(10'h000, 2'h2);
      t_adc(10'h3ff, 2'h2);
      t_adc(10'h200, 2'h2);
      t_adc_busy();
      t_adc(10'h155, 2'h1);
      close_out();
   end
   initial
   begin
      #(3000 * 50);
      fail_count++;
      close_out();
   end
endmodule
